/* File: uer_defs.vh */
// register offsets, field positions, reset values and timing counts for the usb event block
`ifndef UER_DEFS_VH
`define UER_DEFS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define UER_OFS_EVENT_STATUS   8'h00
`define UER_OFS_EVENT_ENABLE   8'h04
`define UER_OFS_ERROR_STATUS   8'h08
`define UER_OFS_ERROR_ENABLE   8'h0c
`define UER_OFS_MODE_CTRL      8'h10
`define UER_OFS_XFER_STATUS    8'h14
`define UER_OFS_EP_BASE        8'h40
`define UER_OFS_EP_LAST        8'h7c

// ----------------------------------------
// event bit positions
// ----------------------------------------
`define UER_EV_STALL           7
`define UER_EV_ATTACH          6
`define UER_EV_RESUME          5
`define UER_EV_IDLE            4
`define UER_EV_TOKEN           3
`define UER_EV_SOF             2
`define UER_EV_ERROR           1
`define UER_EV_RST_DETACH      0

// ----------------------------------------
// error bit positions
// ----------------------------------------
`define UER_ER_STUFF           7
`define UER_ER_OVERRUN         5
`define UER_ER_TURNAROUND      4
`define UER_ER_ALIGN           3
`define UER_ER_CRC16           2
`define UER_ER_CRC5_EOF        1
`define UER_ER_PID             0
`define UER_ER_IMPL_MASK       8'hbf

// ----------------------------------------
// endpoint control bit positions
// ----------------------------------------
`define UER_EP_LOWSPEED        7
`define UER_EP_NORETRY         6
`define UER_EP_CTRL_DIS        4
`define UER_EP_RX_EN           3
`define UER_EP_TX_EN           2
`define UER_EP_STALLED         1
`define UER_EP_HSHK_EN         0
`define UER_EP_IMPL_MASK       8'hdf
`define UER_EP_COMMON_MASK     8'h1f

// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define UER_RESET_BYTE         8'h00
`define UER_CLK_HZ             100000000
`define UER_T_K_NS             2500
`define UER_T_IDLE_US          3000
`define UER_K_CYCLES           ((`UER_T_K_NS * (`UER_CLK_HZ / 1000000) + 999) / 1000)
`define UER_IDLE_CYCLES        (`UER_T_IDLE_US * (`UER_CLK_HZ / 1000000))

`endif

/* File: uer_line_timer.v */
// line state persistence timer: pulses once when a condition has held long enough
`timescale 1ns/100ps
module uer_line_timer #(
	parameter CNT_W = 20,
	parameter [CNT_W-1:0] LIMIT = 20'd250
) (
	input  wire clk_sys_in,
	input  wire rst_n_in,
	input  wire cond_in,
	output reg  hit_out
);
	reg [CNT_W-1:0] count;
	reg             done;

	// ----------------------------------------
	// count while held, fire once per episode
	// ----------------------------------------
	// one pulse per episode so a long state cannot re-raise a flag after software clears it
	always @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			count   <= {CNT_W{1'b0}};
			done    <= 1'b0;
			hit_out <= 1'b0;
		end else if (!cond_in) begin
			count   <= {CNT_W{1'b0}};
			done    <= 1'b0;
			hit_out <= 1'b0;
		end else if (!done && count >= LIMIT - 1'b1) begin
			done    <= 1'b1;
			hit_out <= 1'b1;
		end else begin
			if (!done)
				count <= count + 1'b1;
			hit_out <= 1'b0;
		end
	end
endmodule // uer_line_timer

/* File: uer_event_regs.v */
// usb event, error, enable and endpoint control registers behind an avalon-mm slave
// What this block does
// - device mode sets stall-sent flag when a stall handshake is sent
// - resume flag set after a k-state holds 2.5 us
// - idle flag set after the bus stays idle 3 ms or more
// - token-done flag set when token processing finishes; status readable
// - clearing token-done advances the transfer status fifo
// - frame-start flag set on received sof or host sof threshold
// - summary error flag set only by an enabled error flag
// - device bus reset flag after 2.5 us reset; once per reset
// - host attach flag when not se0 and no activity 2.5 us
// - host detach flag on removal; once until reset state clears
// - flags clear by writing one, attach also clears in device mode; software writes whole words
// - overrun error flag when received bytes exceed buffer count
// - bit-stuff error flag and turnaround timeout flag on their events
// - byte alignment error when data field is not whole bytes
// - data crc error on crc16 failure, pid error on pid failure
// - error bit 1 is token crc5 in device, frame-end in host
// - sixteen endpoint control registers with receive and transmit enables
// - control disable rejects setup only when both directions enabled
// - each endpoint register holds a stalled status bit
// - handshakes happen only when the endpoint handshake enable is set
// - endpoint 0 in host mode holds low-speed and nak retry disable
`timescale 1ns/100ps
`include "uer_defs.vh"
module uer_event_regs #(
	parameter NUM_EP = 16,
	parameter IDLE_CYCLES = `UER_IDLE_CYCLES
) (
	input  wire        clk_sys_in,
	input  wire        rst_n_in,
	input  wire [7:0]  avs_address_in,
	input  wire        avs_read_in,
	input  wire        avs_write_in,
	input  wire [31:0] avs_writedata_in,
	input  wire [3:0]  avs_byteenable_in,
	output reg  [31:0] avs_readdata_out,
	output wire        avs_waitrequest_out,
	input  wire        host_mode_in,
	input  wire        stall_sent_in,
	input  wire        k_state_in,
	input  wire        idle_state_in,
	input  wire        se0_state_in,
	input  wire        bus_activity_in,
	input  wire        token_done_in,
	input  wire [7:0]  token_status_in,
	input  wire        sof_seen_in,
	input  wire        detach_seen_in,
	input  wire        stuff_err_in,
	input  wire        overrun_err_in,
	input  wire        turnaround_err_in,
	input  wire        align_err_in,
	input  wire        crc16_err_in,
	input  wire        crc5_eof_err_in,
	input  wire        pid_err_in,
	input  wire [3:0]  ep_sel_in,
	input  wire        setup_token_in,
	output reg         ep_rx_ok_out,
	output reg         ep_tx_ok_out,
	output reg         ep_setup_ok_out,
	output reg         ep_handshake_out,
	output reg         low_speed_direct_out,
	output reg         nak_retry_out,
	output wire        usb_irq_out
);
	// ----------------------------------------
	// reset release and state
	// ----------------------------------------
	reg        rst_meta;
	reg        rst_sync_n;
	reg [7:0]  usb_event_status;
	reg [7:0]  usb_event_enable;
	reg [7:0]  usb_error_status;
	reg [7:0]  usb_error_enable;
	reg [7:0]  xfer_stat [0:1];
	reg [1:0]  xfer_count;
	reg [7:0]  endpoint_control [0:NUM_EP-1];
	reg        answered;
	reg        detach_seen;
	reg [7:0]  next_event;
	reg [7:0]  next_error;
	reg [7:0]  ev_set;
	reg [7:0]  er_set;
	reg [7:0]  ev_clr;
	reg [7:0]  er_clr;
	reg [7:0]  ep_rd;
	wire       k_hit;
	wire       rst_hit;
	wire       attach_hit;
	wire       idle_hit;
	wire       wr_ok;
	wire       rd_ok;
	wire       ep_hit;
	wire [3:0] ep_idx;
	wire [7:0] ep_cur;
	wire       xfer_pop;
	wire       xfer_push;

	// timer limits cut to the counter width on purpose
	localparam [31:0] K_CYCLES = `UER_K_CYCLES;

	always @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			rst_meta   <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta   <= 1'b1;
			rst_sync_n <= rst_meta;
		end
	end

	// ----------------------------------------
	// line state timers
	// ----------------------------------------
	uer_line_timer #(.CNT_W(20), .LIMIT(K_CYCLES[19:0])) u_k_timer (
		.clk_sys_in (clk_sys_in),
		.rst_n_in   (rst_sync_n),
		.cond_in    (k_state_in),
		.hit_out    (k_hit)
	);
	uer_line_timer #(.CNT_W(20), .LIMIT(K_CYCLES[19:0])) u_rst_timer (
		.clk_sys_in (clk_sys_in),
		.rst_n_in   (rst_sync_n),
		.cond_in    (se0_state_in & ~host_mode_in),
		.hit_out    (rst_hit)
	);
	uer_line_timer #(.CNT_W(20), .LIMIT(K_CYCLES[19:0])) u_attach_timer (
		.clk_sys_in (clk_sys_in),
		.rst_n_in   (rst_sync_n),
		.cond_in    (host_mode_in & ~se0_state_in & ~bus_activity_in),
		.hit_out    (attach_hit)
	);
	uer_line_timer #(.CNT_W(20), .LIMIT(IDLE_CYCLES[19:0])) u_idle_timer (
		.clk_sys_in (clk_sys_in),
		.rst_n_in   (rst_sync_n),
		.cond_in    (idle_state_in),
		.hit_out    (idle_hit)
	);

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	// one wait cycle so read data comes from a flop
	assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~answered;
	// writes land only on the edge where waitrequest is low
	assign wr_ok     = avs_write_in & answered & avs_byteenable_in[0];
	assign rd_ok     = avs_read_in & ~answered;
	assign ep_hit    = (avs_address_in >= `UER_OFS_EP_BASE) && (avs_address_in <= `UER_OFS_EP_LAST);
	assign ep_idx    = avs_address_in[5:2];
	assign ep_cur    = endpoint_control[ep_sel_in];
	assign xfer_pop  = wr_ok && avs_address_in == `UER_OFS_EVENT_STATUS
		&& avs_writedata_in[`UER_EV_TOKEN] && usb_event_status[`UER_EV_TOKEN];
	assign xfer_push = token_done_in && xfer_count != 2'd2;

	// ----------------------------------------
	// flag set and clear terms
	// ----------------------------------------
	always @* begin
		ev_set = 8'h00;
		er_set = 8'h00;
		ev_set[`UER_EV_STALL]  = stall_sent_in & ~host_mode_in;
		ev_set[`UER_EV_ATTACH] = attach_hit;
		ev_set[`UER_EV_RESUME] = k_hit;
		ev_set[`UER_EV_IDLE]   = idle_hit;
		ev_set[`UER_EV_TOKEN]  = token_done_in | (xfer_pop & xfer_count == 2'd2);
		ev_set[`UER_EV_SOF]    = sof_seen_in;
		ev_set[`UER_EV_RST_DETACH] = host_mode_in ? (detach_seen_in & ~detach_seen) : rst_hit;
		er_set[`UER_ER_STUFF]      = stuff_err_in;
		er_set[`UER_ER_TURNAROUND] = turnaround_err_in;
		er_set[`UER_ER_OVERRUN]    = overrun_err_in;
		er_set[`UER_ER_ALIGN]      = align_err_in;
		er_set[`UER_ER_CRC16]      = crc16_err_in;
		er_set[`UER_ER_PID]        = pid_err_in;
		er_set[`UER_ER_CRC5_EOF]   = crc5_eof_err_in;
		ev_clr = 8'h00;
		er_clr = 8'h00;
		if (wr_ok && avs_address_in == `UER_OFS_EVENT_STATUS)
			ev_clr = avs_writedata_in[7:0];
		if (wr_ok && avs_address_in == `UER_OFS_ERROR_STATUS)
			er_clr = avs_writedata_in[7:0];
		// set wins over a clear in the same cycle
		next_error = ((usb_error_status & ~er_clr) | er_set) & `UER_ER_IMPL_MASK;
		ev_set[`UER_EV_ERROR]  = |(next_error & usb_error_enable);
		next_event = (usb_event_status & ~ev_clr) | ev_set;
		if (host_mode_in)
			next_event[`UER_EV_STALL] = usb_event_status[`UER_EV_STALL] & ~ev_clr[`UER_EV_STALL];
		else
			next_event[`UER_EV_ATTACH] = 1'b0;
	end

	// ----------------------------------------
	// register writes
	// ----------------------------------------
	always @(posedge clk_sys_in or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			usb_event_status <= `UER_RESET_BYTE;
			usb_event_enable <= `UER_RESET_BYTE;
			usb_error_status <= `UER_RESET_BYTE;
			usb_error_enable <= `UER_RESET_BYTE;
			detach_seen      <= 1'b0;
			answered         <= 1'b0;
		end else begin
			answered         <= (avs_read_in | avs_write_in) & ~answered;
			usb_event_status <= next_event;
			usb_error_status <= next_error;
			// detach holds off until the host returns the line to reset state
			if (!host_mode_in || se0_state_in)
				detach_seen <= 1'b0;
			else if (detach_seen_in)
				detach_seen <= 1'b1;
			if (wr_ok && avs_address_in == `UER_OFS_EVENT_ENABLE)
				usb_event_enable <= avs_writedata_in[7:0];
			if (wr_ok && avs_address_in == `UER_OFS_ERROR_ENABLE)
				usb_error_enable <= avs_writedata_in[7:0] & `UER_ER_IMPL_MASK;
		end
	end

	// ----------------------------------------
	// transfer status fifo, two entries
	// ----------------------------------------
	// a full fifo drops new tokens; the engine is expected to stall first
	always @(posedge clk_sys_in or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			xfer_stat[0] <= `UER_RESET_BYTE;
			xfer_stat[1] <= `UER_RESET_BYTE;
			xfer_count   <= 2'd0;
		end else if (xfer_pop && xfer_count != 2'd0) begin
			xfer_stat[0] <= (xfer_push && xfer_count == 2'd1) ? token_status_in : xfer_stat[1];
			if (xfer_push && xfer_count == 2'd2)
				xfer_stat[1] <= token_status_in;
			if (!xfer_push)
				xfer_count <= xfer_count - 2'd1;
		end else if (xfer_push) begin
			xfer_stat[xfer_count[0]] <= token_status_in;
			xfer_count <= xfer_count + 2'd1;
		end
	end

	// ----------------------------------------
	// endpoint control registers
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < NUM_EP; g = g + 1) begin : g_ep
			always @(posedge clk_sys_in or negedge rst_sync_n) begin
				if (!rst_sync_n) begin
					endpoint_control[g] <= `UER_RESET_BYTE;
				end else begin
					if (wr_ok && ep_hit && ep_idx == g)
						endpoint_control[g] <= avs_writedata_in[7:0]
							& ((g == 0) ? `UER_EP_IMPL_MASK : `UER_EP_COMMON_MASK);
					// a stall in the same cycle as a write still shows up
					if (stall_sent_in && ep_sel_in == g)
						endpoint_control[g][`UER_EP_STALLED] <= 1'b1;
				end
			end
		end
	endgenerate

	// ----------------------------------------
	// endpoint permissions for the engine
	// ----------------------------------------
	always @(posedge clk_sys_in or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			ep_rx_ok_out         <= 1'b0;
			ep_tx_ok_out         <= 1'b0;
			ep_setup_ok_out      <= 1'b0;
			ep_handshake_out     <= 1'b0;
			low_speed_direct_out <= 1'b0;
			nak_retry_out        <= 1'b0;
		end else begin
			ep_rx_ok_out     <= ep_cur[`UER_EP_RX_EN];
			ep_tx_ok_out     <= ep_cur[`UER_EP_TX_EN];
			ep_setup_ok_out  <= setup_token_in & ep_cur[`UER_EP_RX_EN] & ep_cur[`UER_EP_TX_EN]
				& ~ep_cur[`UER_EP_CTRL_DIS];
			ep_handshake_out <= ep_cur[`UER_EP_HSHK_EN];
			low_speed_direct_out <= host_mode_in & endpoint_control[0][`UER_EP_LOWSPEED];
			nak_retry_out    <= host_mode_in & ~endpoint_control[0][`UER_EP_NORETRY];
		end
	end

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	always @* begin
		ep_rd = endpoint_control[ep_idx];
		if (ep_idx != 4'd0 || !host_mode_in)
			ep_rd = ep_rd & `UER_EP_COMMON_MASK;
	end

	always @(posedge clk_sys_in or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			avs_readdata_out <= 32'h0000_0000;
		end else if (rd_ok) begin
			avs_readdata_out <= 32'h0000_0000;
			if (ep_hit)
				avs_readdata_out[7:0] <= ep_rd;
			else
				case (avs_address_in)
					`UER_OFS_EVENT_STATUS: avs_readdata_out[7:0] <= usb_event_status;
					`UER_OFS_EVENT_ENABLE: avs_readdata_out[7:0] <= usb_event_enable
						& (host_mode_in ? 8'hff : 8'hbf);
					`UER_OFS_ERROR_STATUS: avs_readdata_out[7:0] <= usb_error_status;
					`UER_OFS_ERROR_ENABLE: avs_readdata_out[7:0] <= usb_error_enable;
					`UER_OFS_MODE_CTRL:    avs_readdata_out[0] <= host_mode_in;
					`UER_OFS_XFER_STATUS:  avs_readdata_out[7:0] <= xfer_stat[0];
					default:               avs_readdata_out <= 32'h0000_0000;
				endcase
		end
	end

	// ----------------------------------------
	// interrupt request
	// ----------------------------------------
	assign usb_irq_out = |(usb_event_status & usb_event_enable
		& (host_mode_in ? 8'hff : 8'hbf));
endmodule // uer_event_regs

/* File: uer_monitor.sv */
// concurrent checks on the ports of the usb event register block
`timescale 1ns/100ps
`include "uer_defs.vh"
module uer_monitor (
	input wire        clk_sys_in,
	input wire        rst_n_in,
	input wire [7:0]  avs_address_in,
	input wire        avs_read_in,
	input wire        avs_write_in,
	input wire [31:0] avs_readdata_out,
	input wire        avs_waitrequest_out,
	input wire        host_mode_in,
	input wire [3:0]  ep_sel_in,
	input wire        ep_rx_ok_out,
	input wire        ep_tx_ok_out,
	input wire        ep_setup_ok_out,
	input wire        low_speed_direct_out
);
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);
	// ----------------------------------------
	// bus steps
	// ----------------------------------------
	sequence s_req_wait;
		(avs_read_in || avs_write_in) && avs_waitrequest_out;
	endsequence
	sequence s_rd_done;
		avs_read_in && !avs_waitrequest_out;
	endsequence
	// ----------------------------------------
	// properties
	// ----------------------------------------
	a_wait_first: assert property ($rose(avs_read_in) |-> avs_waitrequest_out)
		else $error("read taken without wait state");
	a_one_wait: assert property (s_req_wait |=> !avs_waitrequest_out)
		else $error("more than one wait state");
	a_upper_zero: assert property (s_rd_done |-> avs_readdata_out[31:8] == 24'h0)
		else $error("upper read bits not zero");
	a_attach_dev: assert property (s_rd_done ##0 (!host_mode_in && avs_address_in <= `UER_OFS_EVENT_ENABLE)
		|-> !avs_readdata_out[6]) else $error("attach bit seen in device mode");
	a_err_gap: assert property (s_rd_done ##0 (avs_address_in == `UER_OFS_ERROR_STATUS
		|| avs_address_in == `UER_OFS_ERROR_ENABLE) |-> !avs_readdata_out[6]) else $error("error bit 6 not zero");
	a_ep_upper: assert property (s_rd_done ##0 (avs_address_in > `UER_OFS_EP_BASE
		&& avs_address_in <= `UER_OFS_EP_LAST) |-> avs_readdata_out[7:5] == 3'h0) else $error("ep bits 7:5 set");
	// setup only makes sense on a fully bidirectional endpoint
	a_setup_both: assert property (ep_setup_ok_out |-> ep_rx_ok_out && ep_tx_ok_out)
		else $error("setup allowed on one-way endpoint");
	a_lowspeed: assert property (low_speed_direct_out |-> $past(host_mode_in))
		else $error("low speed outside host ep0");
endmodule // uer_monitor
bind uer_event_regs uer_monitor u_mon (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
	.avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
	.avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
	.host_mode_in(host_mode_in), .ep_sel_in(ep_sel_in), .ep_rx_ok_out(ep_rx_ok_out),
	.ep_tx_ok_out(ep_tx_ok_out), .ep_setup_ok_out(ep_setup_ok_out), .low_speed_direct_out(low_speed_direct_out));

/* File: uer_usb_partner.sv */
// behavioural usb line partner: turns a line code into line state levels
`timescale 1ns/100ps
module uer_usb_partner (
	input  wire       clk_sys_in,
	input  wire [1:0] line_in,
	output reg        k_state_out = 1'b0,
	output reg        idle_state_out = 1'b0,
	output reg        se0_state_out = 1'b0,
	output reg        bus_activity_out = 1'b0
);
	// ----------------------------------------
	// codes: 0 idle, 1 k-state, 2 se0, 3 traffic
	// ----------------------------------------
	always @(posedge clk_sys_in) begin
		k_state_out <= (line_in == 2'h1);
		idle_state_out <= (line_in == 2'h0);
		se0_state_out <= (line_in == 2'h2);
		// traffic toggles so no steady level hides activity
		bus_activity_out <= (line_in == 2'h3) && !bus_activity_out;
	end
endmodule // uer_usb_partner

/* File: uer_event_regs_tb.sv */
// self-checking bench for the usb event and endpoint register block
`timescale 1ns/100ps
`include "uer_defs.vh"
module uer_event_regs_tb;
	localparam [7:0] ES = `UER_OFS_EVENT_STATUS;
	localparam [7:0] EE = `UER_OFS_EVENT_ENABLE;
	localparam [7:0] RS = `UER_OFS_ERROR_STATUS;
	localparam [7:0] RE = `UER_OFS_ERROR_ENABLE;
	localparam [7:0] EP = `UER_OFS_EP_BASE;
	reg         clk_sys_in = 1'b0;
	reg         rst_n_in = 1'b0;
	reg  [7:0]  adr = 8'h00;
	reg         rd = 1'b0;
	reg         wr_s = 1'b0;
	reg  [31:0] wd = 32'h0;
	reg  [3:0]  be = 4'hf;
	reg         host = 1'b0;
	reg  [3:0]  ev_v = 4'h0;
	reg  [7:0]  err_v = 8'h00;
	reg  [7:0]  tok = 8'h00;
	reg  [3:0]  sel = 4'h0;
	reg         setup = 1'b0;
	reg  [1:0]  line = 2'h3;
	wire [31:0] rdata;
	wire        wreq, k_st, idle_st, se0_st, act, rx_ok, tx_ok, setup_ok, hshk, lsd, retry, irq;
	integer     error_cnt = 0;
	integer     n_tests = 0;
	integer     seed = 90284;
	integer     i;
	reg  [31:0] q, d, e, ep0;
	always #5 clk_sys_in = ~clk_sys_in;
	uer_usb_partner u_bus (.clk_sys_in(clk_sys_in), .line_in(line), .k_state_out(k_st),
		.idle_state_out(idle_st), .se0_state_out(se0_st), .bus_activity_out(act));
	uer_event_regs #(.NUM_EP(16), .IDLE_CYCLES(50)) uut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
		.avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr_s), .avs_writedata_in(wd),
		.avs_byteenable_in(be), .avs_readdata_out(rdata), .avs_waitrequest_out(wreq), .host_mode_in(host),
		.stall_sent_in(ev_v[3]), .k_state_in(k_st), .idle_state_in(idle_st), .se0_state_in(se0_st),
		.bus_activity_in(act), .token_done_in(ev_v[2]), .token_status_in(tok), .sof_seen_in(ev_v[1]),
		.detach_seen_in(ev_v[0]), .stuff_err_in(err_v[7]), .overrun_err_in(err_v[5]),
		.turnaround_err_in(err_v[4]), .align_err_in(err_v[3]), .crc16_err_in(err_v[2]),
		.crc5_eof_err_in(err_v[1]), .pid_err_in(err_v[0]), .ep_sel_in(sel), .setup_token_in(setup),
		.ep_rx_ok_out(rx_ok), .ep_tx_ok_out(tx_ok), .ep_setup_ok_out(setup_ok), .ep_handshake_out(hshk),
		.low_speed_direct_out(lsd), .nak_retry_out(retry), .usb_irq_out(irq));
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task check(input [31:0] got, input [31:0] exp);
		begin
			n_tests = n_tests + 1;
			if (got !== exp) begin
				error_cnt = error_cnt + 1;
				$display("unexpected at %0t: got %h want %h", $time, got, exp);
			end
		end
	endtask
	// answer edge is taken from the design, never assumed
	task bus(input w, input [7:0] a, input [31:0] v);
		integer n;
		begin
			n = 0;
			@(posedge clk_sys_in);
			adr <= a;
			wd <= v;
			wr_s <= w;
			rd <= !w;
			do begin
				@(posedge clk_sys_in);
				n = n + 1;
			end while (wreq !== 1'b0 && n < 20);
			q = rdata;
			if (n >= 20) check(32'h1, 32'h0);
			wr_s <= 1'b0;
			rd <= 1'b0;
		end
	endtask
	task wr(input [7:0] a, input [31:0] v);
		bus(1'b1, a, v);
	endtask
	task rdc(input [7:0] a, input [31:0] x);
		begin
			bus(1'b0, a, 32'h0);
			check(q, x);
		end
	endtask
	task pulse(input [3:0] ev, input [7:0] er);
		begin
			@(posedge clk_sys_in);
			ev_v <= ev;
			err_v <= er;
			@(posedge clk_sys_in);
			ev_v <= 4'h0;
			err_v <= 8'h00;
		end
	endtask
	task hold(input [1:0] l, input integer n);
		begin
			line <= l;
			repeat (n) @(posedge clk_sys_in);
		end
	endtask
	task test_done;
		begin
			$display("checks %0d mismatches %0d", n_tests, error_cnt);
			if (error_cnt == 0 && n_tests > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		repeat (10) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		repeat (3) @(posedge clk_sys_in);
		for (i = 0; i < 22; i = i + 1)
			rdc(8'((i < 6) ? 4 * i : 64 + 4 * (i - 6)), 32'h0);
		wr(8'h30, 32'hff);
		rdc(8'h30, 32'h0);
		host <= 1'b1;
		wr(EE, 32'hffffffff);
		rdc(EE, 32'hff);
		host <= 1'b0;
		rdc(EE, 32'hbf);
		wr(RE, 32'hff);
		be <= 4'he;
		wr(RE, 32'h0);
		be <= 4'hf;
		rdc(RE, 32'hbf);
		$display("test 1 done");
		for (i = 0; i < 6; i = i + 1) begin
			d = $random(seed) & 32'hbf;
			e = $random(seed) & 32'hbf;
			wr(RE, e);
			pulse(4'h8, d[7:0]);
			rdc(RS, d);
			rdc(ES, {24'h0, 6'h20, |(d & e), 1'b0});
			wr(RS, 32'hff);
			wr(ES, 32'hff);
			rdc(ES, 32'h0);
		end
		rdc(EP, 32'h2);
		wr(EP, 32'h0);
		pulse(4'ha, 8'h00);
		wr(ES, 32'h0);
		check({31'h0, irq}, 32'h1);
		rdc(ES, 32'h84);
		wr(ES, 32'h80);
		rdc(ES, 32'h04);
		wr(ES, 32'h04);
		rdc(ES, 32'h0);
		check({31'h0, irq}, 32'h0);
		$display("test 2 done");
		hold(2'h1, 260);
		rdc(ES, 32'h20);
		wr(ES, 32'h20);
		hold(2'h1, 260);
		rdc(ES, 32'h0);
		hold(2'h2, 260);
		rdc(ES, 32'h1);
		wr(ES, 32'h1);
		hold(2'h2, 260);
		rdc(ES, 32'h0);
		hold(2'h3, 5);
		hold(2'h2, 200);
		hold(2'h3, 5);
		rdc(ES, 32'h0);
		hold(2'h0, 60);
		rdc(ES, 32'h10);
		wr(ES, 32'hff);
		host <= 1'b1;
		hold(2'h0, 260);
		rdc(ES, 32'h40);
		hold(2'h3, 2);
		wr(ES, 32'hff);
		$display("test 3 done");
		pulse(4'h1, 8'h00);
		rdc(ES, 32'h1);
		wr(ES, 32'h1);
		pulse(4'h1, 8'h00);
		rdc(ES, 32'h0);
		hold(2'h2, 5);
		hold(2'h3, 2);
		pulse(4'h1, 8'h00);
		rdc(ES, 32'h1);
		wr(ES, 32'h1);
		tok <= 8'h5a;
		pulse(4'h4, 8'h00);
		tok <= 8'ha5;
		pulse(4'h4, 8'h00);
		rdc(`UER_OFS_XFER_STATUS, 32'h5a);
		wr(ES, 32'h8);
		rdc(ES, 32'h8);
		rdc(`UER_OFS_XFER_STATUS, 32'ha5);
		wr(ES, 32'h8);
		rdc(ES, 32'h0);
		$display("test 4 done");
		for (i = 0; i < 16; i = i + 1) begin
			d = $random(seed);
			wr(8'(64 + 4 * i), d);
			e = d & ((i == 0) ? 32'hdf : 32'h1f);
			if (i == 0)
				ep0 = e;
			rdc(8'(64 + 4 * i), e);
			sel <= i[3:0];
			setup <= 1'b1;
			repeat (2) @(posedge clk_sys_in);
			check({hshk, lsd, setup_ok, rx_ok, tx_ok}, {e[0], ep0[7], e[3] & e[2] & ~e[4], e[3], e[2]});
			if (i == 0)
				check({31'h0, retry}, {31'h0, ~e[6]});
		end
		wr(EP, 32'hff);
		host <= 1'b0;
		rdc(EP, 32'h1f);
		$display("test 5 done");
		test_done;
	end
	// normal run stays under a few thousand cycles
	initial begin
		#200000;
		error_cnt = error_cnt + 1;
		$display("unexpected at %0t: watchdog", $time);
		test_done;
	end
endmodule // uer_event_regs_tb
